// File: hw/timer2_capture_reload.sv
// 16-bit timer/counter with capture and auto-reload behind an avalon slave
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
module timer2_capture_reload (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire timer2_pkg::avs_req_t avs_req,
   output logic [timer2_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // external pins
   input wire logic count_input_pin,
   input wire logic trigger_input_pin,
   // interrupt
   output logic irq
);

   typedef struct packed {
      timer2_pkg::pin_sync_t count_pin;
      timer2_pkg::pin_sync_t trig_pin;
      logic prescale;
      logic [15:0] count;
      logic [15:0] reload;
      logic [7:0] control;
      logic [timer2_pkg::IRQ_W-1:0] irq_status;
      logic [timer2_pkg::IRQ_W-1:0] irq_mask;
      logic waitreq;
      logic [timer2_pkg::DATA_W-1:0] rdata;
      logic irq;
   } state_t;

   state_t state_q;
   state_t state_d;

   // a change counts once the second and third stages agree
   function automatic timer2_pkg::pin_sync_t sync_step(input timer2_pkg::pin_sync_t cur, input logic pin);
      timer2_pkg::pin_sync_t nxt;
      nxt.sync = {cur.sync[1:0], pin};
      nxt.level = (cur.sync[1] == cur.sync[2]) ? cur.sync[2] : cur.level;
      return nxt;
   endfunction

   function automatic logic falling(input timer2_pkg::pin_sync_t cur);
      logic f;
      f = cur.level && (cur.sync[1] == cur.sync[2]) && !cur.sync[2];
      return f;
   endfunction

   // one bit of the control byte
   function automatic logic ctl_bit(input logic [7:0] ctl, input int pos);
      logic b;
      b = ctl[pos];
      return b;
   endfunction

   // either serial baud select forces overflow auto-reload
   function automatic logic baud_forced(input logic [7:0] ctl);
      logic b;
      b = ctl_bit(ctl, timer2_pkg::BIT_RX_BAUD_SEL) || ctl_bit(ctl, timer2_pkg::BIT_TX_BAUD_SEL);
      return b;
   endfunction

   // counter after one step; wraps to zero past the top
   function automatic logic [15:0] incr(input logic [15:0] c);
      logic [15:0] n;
      n = c + 16'h0001;
      return n;
   endfunction

   // indices that answer; all others read zero and drop writes
   function automatic logic is_mapped(input logic [7:0] ix);
      logic m;
      m = 1'b0;
      unique case (ix)
         timer2_pkg::IDX_CONTROL,
         timer2_pkg::IDX_RELOAD_LOW,
         timer2_pkg::IDX_RELOAD_HIGH,
         timer2_pkg::IDX_COUNT_LOW,
         timer2_pkg::IDX_COUNT_HIGH,
         timer2_pkg::IDX_IRQ_STATUS,
         timer2_pkg::IDX_IRQ_MASK: m = 1'b1;
         default: m = 1'b0;
      endcase
      return m;
   endfunction

   // byte register widened onto the bus data lanes
   function automatic logic [timer2_pkg::DATA_W-1:0] bus_word(input logic [7:0] b);
      logic [timer2_pkg::DATA_W-1:0] w;
      w = timer2_pkg::RDATA_ZERO;
      w[7:0] = b;
      return w;
   endfunction

   // write-one-to-clear status; a same-cycle event stays set
   function automatic logic [timer2_pkg::IRQ_W-1:0] next_status(input logic [timer2_pkg::IRQ_W-1:0] cur,
         input logic [timer2_pkg::IRQ_W-1:0] clr, input logic [timer2_pkg::IRQ_W-1:0] set);
      logic [timer2_pkg::IRQ_W-1:0] n;
      n = (cur & ~clr) | set;
      return n;
   endfunction

   // interrupt request level from status and mask
   function automatic logic irq_level(input logic [timer2_pkg::IRQ_W-1:0] st, input logic [timer2_pkg::IRQ_W-1:0] mk);
      logic l;
      l = |(st & mk);
      return l;
   endfunction

   function automatic logic [7:0] read_reg(input logic [7:0] idx, input state_t s);
      logic [7:0] v;
      v = timer2_pkg::RST_BYTE;
      unique case (idx)
         timer2_pkg::IDX_CONTROL: v = s.control;
         timer2_pkg::IDX_RELOAD_LOW: v = s.reload[7:0];
         timer2_pkg::IDX_RELOAD_HIGH: v = s.reload[15:8];
         timer2_pkg::IDX_COUNT_LOW: v = s.count[7:0];
         timer2_pkg::IDX_COUNT_HIGH: v = s.count[15:8];
         timer2_pkg::IDX_IRQ_STATUS: v = {6'h00, s.irq_status};
         timer2_pkg::IDX_IRQ_MASK: v = {6'h00, s.irq_mask};
         default: v = timer2_pkg::RST_BYTE;
      endcase
      return v;
   endfunction

   // bus decode
   logic [7:0] idx;
   logic bus_req;
   logic wr_now;
   logic rd_now;
   logic [7:0] wbyte;

   // mode decode
   logic run;
   logic baud_mode;
   logic trig_en;
   logic capture_mode;

   // pin and counter events
   logic count_fall;
   logic trig_fall;
   logic step;
   logic overflow;
   logic trig_act;

   // flag and interrupt updates
   logic set_ovf;
   logic [timer2_pkg::IRQ_W-1:0] irq_set;
   logic [timer2_pkg::IRQ_W-1:0] status_next;

   // behaviour worth knowing before using this block:
   // - pins pass three flops, so counts and triggers land three to
   //   four clocks after the pin falls; a level shorter than two
   //   clocks can be lost
   // - the 16-bit count and reload values are two independent bytes
   //   with no shadow latch; reading them while running may tear
   // - a software write to a count or reload byte beats a hardware
   //   update of that byte in the same cycle
   // - hardware flag sets beat a software clear in the same cycle,
   //   so an event is never lost
   // - in capture mode an overflow wraps the counter to zero
   // - the timer prescaler restarts whenever the run bit is cleared,
   //   so the first step comes two clocks after run is set
   // - every access costs one wait cycle and the slave then shows
   //   waitrequest high for one cycle before the next access
   // - read data is only moved by reads, so it stands afterwards
   // - writes with byte lane zero disabled are dropped
   always_comb begin
      state_d = state_q;
      idx = avs_req.address[timer2_pkg::IDX_LSB +: timer2_pkg::IDX_W];
      bus_req = avs_req.read || avs_req.write;
      // a write takes effect at the edge where waitrequest is sampled low
      wr_now = avs_req.write && !state_q.waitreq && avs_req.byteenable[0] && is_mapped(idx);
      // only reads move the read data, so it stands until the next read
      rd_now = avs_req.read && state_q.waitreq;
      wbyte = avs_req.writedata[7:0];

      run = ctl_bit(state_q.control, timer2_pkg::BIT_RUN_CONTROL);
      baud_mode = baud_forced(state_q.control);
      trig_en = ctl_bit(state_q.control, timer2_pkg::BIT_TRIGGER_ENABLE);
      capture_mode = ctl_bit(state_q.control, timer2_pkg::BIT_CAPTURE_RELOAD) && !baud_mode;

      state_d.count_pin = sync_step(state_q.count_pin, count_input_pin);
      state_d.trig_pin = sync_step(state_q.trig_pin, trigger_input_pin);
      count_fall = falling(state_q.count_pin);
      trig_fall = falling(state_q.trig_pin);

      state_d.prescale = run ? !state_q.prescale : 1'b0;
      if (ctl_bit(state_q.control, timer2_pkg::BIT_COUNT_SOURCE)) begin
         step = run && count_fall;
      end else begin
         step = run && state_q.prescale;
      end
      overflow = step && (state_q.count == timer2_pkg::COUNT_MAX);
      trig_act = trig_en && trig_fall;

      if (step) begin
         state_d.count = incr(state_q.count);
      end
      if (overflow && !capture_mode) begin
         state_d.count = state_q.reload;
      end
      if (trig_act && !capture_mode) begin
         state_d.count = state_q.reload;
      end
      if (trig_act && capture_mode) begin
         state_d.reload = state_q.count;
      end

      set_ovf = overflow && !baud_mode;
      irq_set = '0;
      irq_set[timer2_pkg::IRQ_OVERFLOW] = set_ovf;
      irq_set[timer2_pkg::IRQ_TRIGGER] = trig_act;

      // software register writes; hardware flag sets win over clears
      if (wr_now) begin
         unique case (idx)
            timer2_pkg::IDX_CONTROL: state_d.control = wbyte;
            timer2_pkg::IDX_RELOAD_LOW: state_d.reload[7:0] = wbyte;
            timer2_pkg::IDX_RELOAD_HIGH: state_d.reload[15:8] = wbyte;
            timer2_pkg::IDX_COUNT_LOW: state_d.count[7:0] = wbyte;
            timer2_pkg::IDX_COUNT_HIGH: state_d.count[15:8] = wbyte;
            timer2_pkg::IDX_IRQ_MASK: state_d.irq_mask = wbyte[timer2_pkg::IRQ_W-1:0];
            default: state_d.control = state_d.control;
         endcase
      end
      if (set_ovf) begin
         state_d.control[timer2_pkg::BIT_OVERFLOW_FLAG] = 1'b1;
      end
      if (trig_act) begin
         state_d.control[timer2_pkg::BIT_TRIGGER_EVENT_FLAG] = 1'b1;
      end

      // status clear mask from a write to the status index
      status_next = '0;
      if (wr_now && (idx == timer2_pkg::IDX_IRQ_STATUS)) begin
         status_next = wbyte[timer2_pkg::IRQ_W-1:0];
      end
      state_d.irq_status = next_status(state_q.irq_status, status_next, irq_set);
      state_d.irq = irq_level(state_d.irq_status, state_d.irq_mask);

      // one wait cycle per access, then release for one cycle
      if (bus_req && state_q.waitreq) begin
         state_d.waitreq = 1'b0;
      end else begin
         state_d.waitreq = 1'b1;
      end
      // latched on the wait cycle so it is settled when waitrequest drops
      if (rd_now) begin
         state_d.rdata = bus_word(read_reg(idx, state_q));
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q.count_pin <= '0;
         state_q.trig_pin <= '0;
         state_q.prescale <= 1'b0;
         state_q.count <= timer2_pkg::RST_WORD;
         state_q.reload <= timer2_pkg::RST_WORD;
         state_q.control <= timer2_pkg::RST_BYTE;
         state_q.irq_status <= '0;
         state_q.irq_mask <= '0;
         state_q.waitreq <= 1'b1;
         state_q.rdata <= timer2_pkg::RDATA_ZERO;
         state_q.irq <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   assign avs_readdata = state_q.rdata;
   assign avs_waitrequest = state_q.waitreq;
   assign irq = state_q.irq;

endmodule

// File: common/timer2_pkg.sv
// register map, field layout and carrier types of the capture/reload timer
package timer2_pkg;

   // avalon byte address width; printed offsets are register indices
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int IDX_LSB = 2;
   localparam int IDX_W = 8;

   // register indices (byte address is four times the index)
   localparam logic [7:0] IDX_CONTROL = 8'hc8;
   localparam logic [7:0] IDX_RELOAD_LOW = 8'hca;
   localparam logic [7:0] IDX_RELOAD_HIGH = 8'hcb;
   localparam logic [7:0] IDX_COUNT_LOW = 8'hcc;
   localparam logic [7:0] IDX_COUNT_HIGH = 8'hcd;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h41;

   // timer_control_register bit positions
   localparam int BIT_OVERFLOW_FLAG = 7;
   localparam int BIT_TRIGGER_EVENT_FLAG = 6;
   localparam int BIT_RX_BAUD_SEL = 5;
   localparam int BIT_TX_BAUD_SEL = 4;
   localparam int BIT_TRIGGER_ENABLE = 3;
   localparam int BIT_RUN_CONTROL = 2;
   localparam int BIT_COUNT_SOURCE = 1;
   localparam int BIT_CAPTURE_RELOAD = 0;

   // interrupt status / mask bit positions
   localparam int IRQ_OVERFLOW = 0;
   localparam int IRQ_TRIGGER = 1;
   localparam int IRQ_W = 2;

   // reset values and counter top value
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   // timer mode advances once per this many system clocks
   localparam int TIMER_DIV = 2;

   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic read;
      logic write;
      logic [DATA_W-1:0] writedata;
      logic [3:0] byteenable;
   } avs_req_t;

   // three-stage pin synchroniser plus filtered level
   typedef struct packed {
      logic [2:0] sync;
      logic level;
   } pin_sync_t;

endpackage

// File: verif/timer2_properties.sv
// checker for bus, interrupt and reset behaviour of the timer
`timescale 1ns/1ps
module timer2_properties (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // watched ports
   input wire timer2_pkg::avs_req_t avs_req,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic count_input_pin,
   input wire logic trigger_input_pin,
   input wire logic irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic rq;
   logic [7:0] ix;
   assign rq = avs_req.read | avs_req.write;
   assign ix = avs_req.address[9:2];
   property p_ans; rq && avs_waitrequest |=> !avs_waitrequest; endproperty
   property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   property p_idle; !rq |=> avs_waitrequest; endproperty
   property p_top; avs_readdata[31:8] == 24'h0; endproperty
   property p_hold; !(avs_req.read && avs_waitrequest) |=> $stable(avs_readdata); endproperty
   property p_unm;
      avs_req.read && avs_waitrequest && !(ix inside {8'hc8, [8'hca:8'hcd], 8'h40, 8'h41}) |=> avs_readdata == 0;
   endproperty
   property p_msk;
      avs_req.write && !avs_waitrequest && ix == 8'h41 && avs_req.byteenable[0] && avs_req.writedata[1:0] == 2'b00
      |-> ##2 !irq;
   endproperty
   property p_rst; !$past(rst_n) |-> avs_waitrequest && !irq && avs_readdata == 0; endproperty
   a_ans: assert property (p_ans) else $error("bus answer late");
   a_one: assert property (p_one) else $error("wait low too long");
   a_idle: assert property (p_idle) else $error("answer without request");
   a_top: assert property (p_top) else $error("read upper bits set");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_unm: assert property (p_unm) else $error("unmapped read nonzero");
   a_msk: assert property (p_msk) else $error("masked irq high");
   a_rst: assert property (p_rst) else $error("reset outputs wrong");
   cover property (avs_req.read && !avs_waitrequest);
   cover property (avs_req.write && !avs_waitrequest);
   cover property ($rose(irq));
endmodule
bind timer2_capture_reload timer2_properties u_props (.core_clk(core_clk), .rst_n(rst_n), .avs_req(avs_req),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .count_input_pin(count_input_pin),
   .trigger_input_pin(trigger_input_pin), .irq(irq));

// File: verif/timer2_pin_model.sv
// model of the external count and trigger pins
`timescale 1ns/1ps
module timer2_pin_model (
   // clock
   input wire logic core_clk,
   // pins, idle high
   output logic count_input_pin,
   output logic trigger_input_pin
);
   initial begin
      count_input_pin = 1'b1;
      trigger_input_pin = 1'b1;
   end
   task automatic fall(input bit trg, input int n);
      repeat (n) begin
         @(posedge core_clk);
         if (trg) trigger_input_pin <= 1'b0;
         else count_input_pin <= 1'b0;
         repeat (4) @(posedge core_clk);
         trigger_input_pin <= 1'b1;
         count_input_pin <= 1'b1;
         repeat (4) @(posedge core_clk);
      end
   endtask
endmodule

// File: verif/tb_top.sv
// self-checking bench of the capture/reload timer
`timescale 1ns/1ps
module tb_top;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   timer2_pkg::avs_req_t req = '0;
   logic [31:0] rdata;
   logic wreq, irq, cpin, tpin;
   logic [7:0] v, r, h;
   int bad_count = 0;
   int compares = 0;
   int n;
   logic [7:0] map [7] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'h40, 8'h41};
   always #4 core_clk = ~core_clk;
   timer2_capture_reload DUT (.core_clk(core_clk), .rst_n(rst_n), .avs_req(req), .avs_readdata(rdata),
      .avs_waitrequest(wreq), .count_input_pin(cpin), .trigger_input_pin(tpin), .irq(irq));
   timer2_pin_model u_pins (.core_clk(core_clk), .count_input_pin(cpin), .trigger_input_pin(tpin));
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         bad_count++;
      end
   endtask
   // held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      req <= '{address: {ix, 2'b00}, read: !w, write: w, writedata: {24'h0, d}, byteenable: 4'hf};
      do begin
         @(posedge core_clk);
         k++;
      end while (wreq !== 1'b0 && k < 50);
      if (wreq !== 1'b0) bad_count++;
      v = rdata[7:0];
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] ix, input logic [7:0] d);
      bus(1'b1, ix, d);
   endtask
   task automatic rc(input string nm, input logic [7:0] ix, input logic [7:0] e);
      bus(1'b0, ix, 8'h00);
      chk(nm, v, e);
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      finish_test;
   end
   initial begin
      void'($urandom(32'hcb1b));
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (map[i]) rc("rst", map[i], 8'h00);
      rc("unmapped", 8'h10, 8'h00);
      $display("reset test end");
      repeat (4) begin
         r = $urandom;
         for (int i = 1; i < 4; i++) begin
            wr(map[i], r ^ map[i]);
            rc("rw", map[i], r ^ map[i]);
         end
      end
      $display("readback test end");
      wr(8'hcc, 8'h00);
      wr(8'hc8, 8'h04);
      repeat (40) @(posedge core_clk);
      wr(8'hc8, 8'h00);
      bus(1'b0, 8'hcc, 8'h00);
      chk("timer", v, 8'h15);
      wr(8'hca, 8'h34);
      wr(8'hcb, 8'h12);
      wr(8'h41, 8'h01);
      // second pass adds baud and capture selects
      for (int m = 0; m < 2; m++) begin
         wr(8'hcc, 8'hfe);
         wr(8'hcd, 8'hff);
         wr(8'hc8, m ? 8'h15 : 8'h04);
         repeat (10) @(posedge core_clk);
         rc("ctl", 8'hc8, m ? 8'h15 : 8'h84);
         rc("st", 8'h40, m ? 8'h00 : 8'h01);
         chk("irq", {7'h0, irq}, m ? 8'h00 : 8'h01);
         wr(8'hc8, 8'h00);
         rc("hi", 8'hcd, 8'h12);
         wr(8'h40, 8'h03);
         repeat (2) @(posedge core_clk);
         chk("irq_clr", {7'h0, irq}, 8'h00);
      end
      $display("overflow test end");
      r = $urandom;
      h = $urandom;
      wr(8'hcc, r);
      wr(8'hca, h);
      wr(8'h41, 8'h02);
      wr(8'hc8, 8'h09);
      u_pins.fall(1'b1, 1);
      rc("cap", 8'hca, r);
      rc("tflag", 8'hc8, 8'h49);
      chk("tirq", {7'h0, irq}, 8'h01);
      wr(8'hca, h);
      wr(8'hc8, 8'h01);
      u_pins.fall(1'b1, 1);
      rc("ign", 8'hca, h);
      rc("noflag", 8'hc8, 8'h01);
      wr(8'hc8, 8'h08);
      u_pins.fall(1'b1, 1);
      rc("rld", 8'hcc, h);
      $display("trigger test end");
      n = $urandom_range(8, 1);
      wr(8'hcc, 8'h00);
      wr(8'hc8, 8'h06);
      u_pins.fall(1'b0, n);
      wr(8'hc8, 8'h00);
      rc("cnt", 8'hcc, 8'(n));
      chk("irq_pend", {7'h0, irq}, 8'h01);
      wr(8'h41, 8'h00);
      repeat (2) @(posedge core_clk);
      chk("irq_mask", {7'h0, irq}, 8'h00);
      $display("counter test end");
      finish_test;
   end
endmodule
